/* core/ddr_init_pkg.sv */
// Shared constants and types for the memory command link
package ddr_init_pkg;
    localparam int CLK_MHZ        = 100;
    localparam int MRD_NS         = 15;
    localparam int RFC_NS         = 120;
    localparam int RP_NS          = 20;
    localparam int MRD_CYC        = (MRD_NS * CLK_MHZ + 999) / 1000;
    localparam int RFC_CYC        = (RFC_NS * CLK_MHZ + 999) / 1000;
    localparam int RP_CYC         = (RP_NS * CLK_MHZ + 999) / 1000;
    localparam int DLL_LOCK_CYC   = 200;
    localparam int ADDR_W         = 14;
    localparam int DQ_W           = 16;
    localparam int BANKS          = 4;
    localparam int DLL_RESET_BIT  = 8;
    localparam int PRE_ALL_BIT    = 10;
    localparam int BURST_MAX      = 8;
    localparam int RD_TAIL_CYC    = 2;
    localparam int CNT_W          = 9;

    // Command code {cs_n, ras_n, cas_n, we_n}
    typedef enum logic [3:0]
    {
        CMD_MRS   = 4'h0,
        CMD_REF   = 4'h1,
        CMD_PRE   = 4'h2,
        CMD_ACT   = 4'h3,
        CMD_WR    = 4'h4,
        CMD_RD    = 4'h5,
        CMD_NOP   = 4'h7,
        CMD_DESEL = 4'h8
    } cmd_t;

    typedef enum logic [1:0]
    {
        PD_NONE,
        PD_PRECHARGE,
        PD_ACTIVE
    } pd_mode_t;
endpackage

/* core/ddr_link_if.sv */
// Command and data link between controller and memory
`timescale 1ns/1ps
`default_nettype none
interface ddr_link_if;
    import ddr_init_pkg::*;
    logic              cke;
    cmd_t              cmd;
    logic [ADDR_W-1:0] addr;
    logic [1:0]        ba;
    logic [DQ_W-1:0]   dq_c;
    logic              dq_c_oe;
    logic [DQ_W-1:0]   dq_m;
    logic              dq_m_oe;
    logic              lower_byte_strobe_c;
    logic              upper_byte_strobe_c;
    logic              strobe_c_oe;
    logic              lower_byte_strobe_m;
    logic              upper_byte_strobe_m;
    logic              strobe_m_oe;

    modport memory
    (
        input  cke, cmd, addr, ba, dq_c, dq_c_oe,
        input  lower_byte_strobe_c, upper_byte_strobe_c, strobe_c_oe,
        output dq_m, dq_m_oe, lower_byte_strobe_m, upper_byte_strobe_m, strobe_m_oe
    );
    modport controller
    (
        output cke, cmd, addr, ba, dq_c, dq_c_oe,
        output lower_byte_strobe_c, upper_byte_strobe_c, strobe_c_oe,
        input  dq_m, dq_m_oe, lower_byte_strobe_m, upper_byte_strobe_m, strobe_m_oe
    );
endinterface
`default_nettype wire

/* core/ddr_mem_end.sv */
// Memory end: mode load, bank tracking, power-down type and read strobes
`timescale 1ns/1ps
`default_nettype none
module ddr_mem_end
#(
    parameter int BURST_LEN = 4
)
(
    input  wire logic                        clk,
    input  wire logic                        arst_n,
    ddr_link_if.memory                       link,
    input  wire logic [ddr_init_pkg::DQ_W-1:0] rd_data,
    output logic [ddr_init_pkg::DQ_W-1:0]    wr_data,
    output logic                             wr_valid,
    output logic [ddr_init_pkg::ADDR_W-1:0]  mode_reg,
    output logic                             dll_reset_seen,
    output logic [1:0]                       refresh_count,
    output ddr_init_pkg::pd_mode_t           pd_mode
);
    import ddr_init_pkg::*;

    initial
    begin
        if (BURST_LEN < 2 || BURST_LEN > BURST_MAX)
            $error("BURST_LEN out of range");
    end

    logic [BANKS-1:0] open_reg;
    logic [3:0]       rd_cnt_reg;
    logic [3:0]       wr_cnt_reg;
    logic             cke_q_reg;
    logic             take;

    assign take = link.cke && cke_q_reg;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cke_q_reg <= 1'b0;
        else
            cke_q_reg <= link.cke;
    end

    // Refreshes count whether before or after the mode load
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode_reg       <= '0;
            dll_reset_seen <= 1'b0;
            refresh_count  <= 2'h0;
        end
        else if (take)
        begin
            if (link.cmd == CMD_MRS)
            begin
                mode_reg <= link.addr;
                if (link.addr[DLL_RESET_BIT])
                    dll_reset_seen <= 1'b1;
            end
            if (link.cmd == CMD_REF && refresh_count != 2'h3)
                refresh_count <= refresh_count + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            open_reg <= '0;
        else if (take)
        begin
            if (link.cmd == CMD_ACT)
                open_reg[link.ba] <= 1'b1;
            else if (link.cmd == CMD_PRE)
            begin
                if (link.addr[PRE_ALL_BIT])
                    open_reg <= '0;
                else
                    open_reg[link.ba] <= 1'b0;
            end
        end
    end

    // Power-down type follows open rows at entry
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pd_mode <= PD_NONE;
        else if (link.cke)
            pd_mode <= PD_NONE;
        else if (cke_q_reg)
        begin
            if (link.cmd == CMD_ACT)
                pd_mode <= PD_ACTIVE;
            else if (link.cmd == CMD_PRE || open_reg == '0)
                pd_mode <= PD_PRECHARGE;
            else
                pd_mode <= PD_ACTIVE;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_cnt_reg <= 4'h0;
            wr_cnt_reg <= 4'h0;
        end
        else
        begin
            if (take && link.cmd == CMD_RD)
                rd_cnt_reg <= 4'(BURST_LEN);
            else if (rd_cnt_reg != 4'h0)
                rd_cnt_reg <= rd_cnt_reg - 4'h1;
            if (take && link.cmd == CMD_WR)
                wr_cnt_reg <= 4'(BURST_LEN);
            else if (wr_cnt_reg != 4'h0)
                wr_cnt_reg <= wr_cnt_reg - 4'h1;
        end
    end

    // One word per cycle; strobe toggles model the per-byte lanes
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            link.dq_m                <= '0;
            link.dq_m_oe             <= 1'b0;
            link.lower_byte_strobe_m <= 1'b0;
            link.upper_byte_strobe_m <= 1'b0;
            link.strobe_m_oe         <= 1'b0;
        end
        else
        begin
            link.dq_m_oe     <= rd_cnt_reg != 4'h0;
            link.strobe_m_oe <= rd_cnt_reg != 4'h0;
            link.dq_m        <= rd_data;
            if (rd_cnt_reg != 4'h0)
            begin
                link.lower_byte_strobe_m <= ~link.lower_byte_strobe_m;
                link.upper_byte_strobe_m <= ~link.upper_byte_strobe_m;
            end
            else
            begin
                link.lower_byte_strobe_m <= 1'b0;
                link.upper_byte_strobe_m <= 1'b0;
            end
        end
    end

    // Whole word taken under the one shared strobe enable; the byte strobes are not looked at
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_data  <= '0;
            wr_valid <= 1'b0;
        end
        else
        begin
            wr_valid <= link.dq_c_oe && link.strobe_c_oe;
            wr_data  <= link.dq_c;
        end
    end
endmodule
`default_nettype wire

/* core/ddr_ctrl_end.sv */
`timescale 1ns/1ps
`default_nettype none
module ddr_ctrl_end
#(
    parameter int BURST_LEN   = 4,
    parameter bit SECOND_LOAD = 1'b1
)
(
    input  wire logic                          clk,
    input  wire logic                          arst_n,
    ddr_link_if.controller                     link,
    input  wire logic [ddr_init_pkg::ADDR_W-1:0] mode_value,
    input  wire logic                          refresh_first,
    input  wire logic                          freq_change,
    input  wire logic                          pd_req,
    input  wire logic                          rd_req,
    input  wire logic                          wr_req,
    input  wire logic [ddr_init_pkg::DQ_W-1:0] wr_word,
    output logic                               rd_ack,
    output logic                               wr_ack,
    output logic                               init_done,
    output logic                               in_power_down
);
    import ddr_init_pkg::*;

    initial
    begin
        if (BURST_LEN < 2 || BURST_LEN > BURST_MAX)
            $error("BURST_LEN out of range");
    end

    typedef enum
    {
        S_PRE,
        S_REF1,
        S_REF2,
        S_MRS,
        S_MRS2,
        S_IDLE,
        S_PD
    } state_t;

    state_t           state_reg;
    logic [CNT_W-1:0] wait_reg;
    logic [CNT_W-1:0] lock_reg;
    logic [3:0]       burst_reg;
    logic             loaded_reg;
    logic             wr_burst_reg;

    logic ready;
    // Commands wait one edge after clock enable rises; the memory ignores the exit edge
    assign ready  = wait_reg == '0 && (link.cke || state_reg == S_PD);
    assign rd_ack = state_reg == S_IDLE && ready && burst_reg == 4'h0 && rd_req && lock_reg == '0;
    assign wr_ack = state_reg == S_IDLE && ready && burst_reg == 4'h0 && wr_req && !rd_ack;

    // Init order; refresh may come before or after the load
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg  <= S_PRE;
            loaded_reg <= 1'b0;
        end
        else if (ready)
        begin
            case (state_reg)
                S_PRE:  state_reg <= refresh_first ? S_REF1 : S_MRS;
                S_REF1: state_reg <= S_REF2;
                S_REF2: state_reg <= loaded_reg ? (SECOND_LOAD ? S_MRS2 : S_IDLE) : S_MRS;
                S_MRS:
                begin
                    loaded_reg <= 1'b1;
                    state_reg  <= refresh_first ? (SECOND_LOAD ? S_MRS2 : S_IDLE) : S_REF1;
                end
                S_MRS2: state_reg <= S_IDLE;
                S_IDLE:
                begin
                    if (freq_change)
                        state_reg <= S_MRS;
                    else if (pd_req && burst_reg == 4'h0 && !rd_req && !wr_req)
                        state_reg <= S_PD;
                end
                S_PD:   if (!pd_req) state_reg <= S_IDLE;
                default: state_reg <= S_PRE;
            endcase
        end
    end

    // Delay per command; only NOP issued while counting
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            wait_reg <= '0;
        else if (wait_reg != '0)
            wait_reg <= wait_reg - CNT_W'(1);
        else if (ready)
            case (state_reg)
                S_PRE:         wait_reg <= CNT_W'(RP_CYC - 1);
                S_REF1, S_REF2: wait_reg <= CNT_W'(RFC_CYC - 1);
                S_MRS, S_MRS2: wait_reg <= CNT_W'(MRD_CYC - 1);
                default:       wait_reg <= '0;
            endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            lock_reg <= '0;
        else if (ready && state_reg == S_MRS)
            lock_reg <= CNT_W'(DLL_LOCK_CYC);
        else if (lock_reg != '0)
            lock_reg <= lock_reg - CNT_W'(1);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            burst_reg    <= 4'h0;
            wr_burst_reg <= 1'b0;
        end
        else if (rd_ack || wr_ack)
        begin
            // Read data drains after the memory's own delay; hold off power-down till then
            burst_reg    <= wr_ack ? 4'(BURST_LEN) : 4'(BURST_LEN + RD_TAIL_CYC);
            wr_burst_reg <= wr_ack;
        end
        else if (burst_reg != 4'h0)
            burst_reg <= burst_reg - 4'h1;
    end

    // Command drive; clock enable high outside power-down, rising one cycle after the state leaves S_PD
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            link.cke  <= 1'b0;
            link.cmd  <= CMD_NOP;
            link.addr <= '0;
            link.ba   <= 2'h0;
        end
        else
        begin
            link.cke  <= !(state_reg == S_PD || (state_reg == S_IDLE && ready && pd_req && burst_reg == 4'h0
                          && !rd_req && !wr_req && !freq_change));
            link.cmd  <= CMD_NOP;
            link.addr <= '0;
            link.ba   <= 2'h0;
            if (ready)
                case (state_reg)
                    S_PRE:
                    begin
                        link.cmd               <= CMD_PRE;
                        link.addr[PRE_ALL_BIT] <= 1'b1;
                    end
                    S_REF1, S_REF2: link.cmd <= CMD_REF;
                    S_MRS:
                    begin
                        link.cmd                 <= CMD_MRS;
                        link.addr                <= mode_value;
                        link.addr[DLL_RESET_BIT] <= 1'b1;
                    end
                    S_MRS2:
                    begin
                        link.cmd                 <= CMD_MRS;
                        link.addr                <= mode_value;
                        link.addr[DLL_RESET_BIT] <= 1'b0;
                    end
                    S_IDLE:
                        if (rd_ack)
                            link.cmd <= CMD_RD;
                        else if (wr_ack)
                            link.cmd <= CMD_WR;
                    default: link.cmd <= CMD_NOP;
                endcase
        end
    end

    // Write data with both byte strobes
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            link.dq_c                <= '0;
            link.dq_c_oe             <= 1'b0;
            link.lower_byte_strobe_c <= 1'b0;
            link.upper_byte_strobe_c <= 1'b0;
            link.strobe_c_oe         <= 1'b0;
        end
        else
        begin
            link.dq_c_oe     <= wr_burst_reg && burst_reg != 4'h0;
            link.strobe_c_oe <= wr_burst_reg && burst_reg != 4'h0;
            link.dq_c        <= wr_word;
            link.lower_byte_strobe_c <= wr_burst_reg && burst_reg != 4'h0 && !link.lower_byte_strobe_c;
            link.upper_byte_strobe_c <= wr_burst_reg && burst_reg != 4'h0 && !link.upper_byte_strobe_c;
        end
    end

    assign init_done     = state_reg == S_IDLE || state_reg == S_PD;
    assign in_power_down = state_reg == S_PD;
endmodule
`default_nettype wire

/* verification/ddr_link_chk.sv */
// Wire-level checks on the command link between the two ends
`timescale 1ns/1ps
`default_nettype none
module ddr_link_chk
(
    input wire logic                            clk,
    input wire logic                            arst_n,
    input wire logic                            cke,
    input wire ddr_init_pkg::cmd_t              cmd,
    input wire logic [ddr_init_pkg::ADDR_W-1:0] addr,
    input wire logic [1:0]                      ba,
    input wire logic [ddr_init_pkg::DQ_W-1:0]   dq_c,
    input wire logic                            dq_c_oe,
    input wire logic                            lower_byte_strobe_c,
    input wire logic                            upper_byte_strobe_c,
    input wire logic                            strobe_c_oe,
    input wire logic [ddr_init_pkg::DQ_W-1:0]   dq_m,
    input wire logic                            dq_m_oe,
    input wire logic                            lower_byte_strobe_m,
    input wire logic                            upper_byte_strobe_m,
    input wire logic                            strobe_m_oe
);
    import ddr_init_pkg::*;
    logic [1:0]        mrs_n_reg;
    logic [1:0]        ref_n_reg;
    logic [ADDR_W-1:0] first_mode_reg;
    logic [CNT_W-1:0]  dll_age_reg;
    logic [3:0]        rfc_left_reg;
    logic              seen_reg;
    wire logic         go = cke && cmd != CMD_NOP && cmd != CMD_DESEL;

    // Age saturates so a long idle spell cannot wrap back under the lock time
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mrs_n_reg <= 2'h0;
            ref_n_reg <= 2'h0;
            first_mode_reg <= '0;
            dll_age_reg <= '0;
            rfc_left_reg <= 4'h0;
            seen_reg <= 1'b0;
        end
        else
        begin
            if (go && cmd == CMD_MRS && mrs_n_reg != 2'h3)
                mrs_n_reg <= mrs_n_reg + 2'h1;
            if (go && cmd == CMD_MRS && mrs_n_reg == 2'h0)
                first_mode_reg <= addr;
            if (go && cmd == CMD_REF && ref_n_reg != 2'h3)
                ref_n_reg <= ref_n_reg + 2'h1;
            dll_age_reg <= (go && cmd == CMD_MRS && addr[DLL_RESET_BIT]) ? '0 : dll_age_reg + CNT_W'(~&dll_age_reg);
            rfc_left_reg <= (go && cmd == CMD_REF) ? 4'(RFC_CYC - 1) : rfc_left_reg - 4'(rfc_left_reg != 4'h0);
            seen_reg <= seen_reg | go;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence quiet_s;
        cke && (cmd == CMD_NOP || cmd == CMD_DESEL);
    endsequence

    pre_first_a: assert property (go && !seen_reg |-> cmd == CMD_PRE && addr[PRE_ALL_BIT])
        else $error("first command is not precharge all");
    dll_load_a: assert property (go && cmd == CMD_MRS && mrs_n_reg == 2'h0 |-> addr[DLL_RESET_BIT])
        else $error("first mode load without dll reset");
    mrd_wait_a: assert property (go && cmd == CMD_MRS |=> quiet_s)
        else $error("command too soon after mode load");
    read_lock_a: assert property (go && cmd == CMD_RD |-> dll_age_reg >= CNT_W'(DLL_LOCK_CYC - 1))
        else $error("read before dll lock time");
    second_load_a: assert property (go && cmd == CMD_MRS && mrs_n_reg == 2'h1 |->
        (addr ^ first_mode_reg) == (ADDR_W'(1) << DLL_RESET_BIT))
        else $error("second mode load differs");
    refresh_pair_a: assert property (go && cmd inside {CMD_ACT, CMD_RD, CMD_WR} |-> ref_n_reg >= 2'h2)
        else $error("access before two refreshes");
    rfc_hold_a: assert property (rfc_left_reg != 4'h0 |-> quiet_s)
        else $error("refresh cycle time broken");
    pd_quiet_a: assert property (!cke |-> cmd == CMD_NOP || cmd == CMD_DESEL)
        else $error("command during power-down");
    pd_burst_a: assert property ($fell(cke) |-> !dq_c_oe && !dq_m_oe)
        else $error("power-down during burst");
    rd_strobe_a: assert property ($rose(dq_m_oe) |-> (dq_m_oe && strobe_m_oe)[*4])
        else $error("read burst without strobes");
    wr_strobe_a: assert property ($rose(dq_c_oe) |-> (dq_c_oe && strobe_c_oe)[*4])
        else $error("write burst without strobes");
endmodule
`default_nettype wire

/* verification/tb.sv */
// Bench joining both link ends and driving their user sides
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
$display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
`define WT(c) begin n = 0; while (!(c) && n < 400) begin @(negedge clk); n++; end end
module tb;
    import ddr_init_pkg::*;
    logic              clk, arst_n, refresh_first, freq_change, pd_req, rd_req, wr_req;
    logic              rd_ack, wr_ack, init_done, in_power_down, wr_valid, dll_reset_seen;
    logic [ADDR_W-1:0] mode_value, mode_reg;
    logic [DQ_W-1:0]   wr_word, rd_data, wr_data;
    logic [1:0]        refresh_count;
    logic [3:0]        open_banks;
    pd_mode_t          pd_mode;
    int                num_errors, checks_done, cyc, dll_cyc, rd_gap, n, k;

    ddr_link_if link();
    ddr_ctrl_end u_ddr_ctrl_end(.clk(clk), .arst_n(arst_n), .link(link), .mode_value(mode_value),
        .refresh_first(refresh_first), .freq_change(freq_change), .pd_req(pd_req), .rd_req(rd_req),
        .wr_req(wr_req), .wr_word(wr_word), .rd_ack(rd_ack), .wr_ack(wr_ack), .init_done(init_done),
        .in_power_down(in_power_down));
    ddr_mem_end u_ddr_mem_end(.clk(clk), .arst_n(arst_n), .link(link), .rd_data(rd_data),
        .wr_data(wr_data), .wr_valid(wr_valid), .mode_reg(mode_reg), .dll_reset_seen(dll_reset_seen),
        .refresh_count(refresh_count), .pd_mode(pd_mode));
    ddr_link_chk u_ddr_link_chk(.clk(clk), .arst_n(arst_n), .cke(link.cke), .cmd(link.cmd),
        .addr(link.addr), .ba(link.ba), .dq_c(link.dq_c), .dq_c_oe(link.dq_c_oe),
        .lower_byte_strobe_c(link.lower_byte_strobe_c), .upper_byte_strobe_c(link.upper_byte_strobe_c),
        .strobe_c_oe(link.strobe_c_oe), .dq_m(link.dq_m), .dq_m_oe(link.dq_m_oe),
        .lower_byte_strobe_m(link.lower_byte_strobe_m), .upper_byte_strobe_m(link.upper_byte_strobe_m),
        .strobe_m_oe(link.strobe_m_oe));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Open banks seen on the wire decide which power-down kind to expect
    always @(posedge clk or negedge arst_n)
        if (!arst_n)
            open_banks <= 4'h0;
        else if (link.cke && link.cmd == CMD_ACT)
            open_banks[link.ba] <= 1'b1;
        else if (link.cke && link.cmd == CMD_PRE)
            open_banks <= link.addr[PRE_ALL_BIT] ? 4'h0 : open_banks & ~(4'h1 << link.ba);

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (link.cke && link.cmd == CMD_MRS && link.addr[DLL_RESET_BIT])
            dll_cyc <= cyc;
        if (link.cke && link.cmd == CMD_RD)
            rd_gap <= cyc - dll_cyc;
    end

    task automatic close_out();
        $display("checks_done %0d num_errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic do_init(input logic rf);
        arst_n = 1'b0;
        refresh_first = rf;
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        `WT(init_done === 1'b1)
        // Memory takes the last load one edge after the state moves on
        @(negedge clk);
        `CHK(init_done, 1'b1)
        `CHK(dll_reset_seen, 1'b1)
        `CHK(refresh_count, 2'h2)
        `CHK(mode_reg, mode_value)
    endtask

    task automatic do_pd();
        pd_mode_t exp;
        exp = (open_banks != 4'h0) ? PD_ACTIVE : PD_PRECHARGE;
        pd_req = 1'b1;
        `WT(in_power_down === 1'b1)
        repeat (2) @(negedge clk);
        `CHK(link.cke, 1'b0)
        `CHK(pd_mode, exp)
        pd_req = 1'b0;
        `WT(in_power_down === 1'b0)
        repeat (2) @(negedge clk);
        `CHK(link.cke, 1'b1)
        `CHK(pd_mode, PD_NONE)
    endtask

    task automatic do_rd(input logic [DQ_W-1:0] d);
        rd_data = d;
        rd_req = 1'b1;
        `WT(rd_ack === 1'b1)
        `CHK(rd_ack, 1'b1)
        @(negedge clk);
        rd_req = 1'b0;
        `WT(link.dq_m_oe === 1'b1)
        `CHK(link.dq_m, d)
        `CHK(rd_gap >= DLL_LOCK_CYC, 1'b1)
        `WT(link.dq_m_oe === 1'b0)
    endtask

    task automatic do_wr(input logic [DQ_W-1:0] d);
        wr_word = d;
        wr_req = 1'b1;
        `WT(wr_ack === 1'b1)
        @(negedge clk);
        wr_req = 1'b0;
        `WT(wr_valid === 1'b1)
        `CHK(wr_data, d)
        `WT(link.dq_c_oe === 1'b0)
    endtask

    initial
    begin
        arst_n = 1'b0;
        mode_value = 14'h0062;
        {refresh_first, freq_change, pd_req, rd_req, wr_req} = 5'h00;
        {wr_word, rd_data} = 32'h0;
        {cyc, dll_cyc, rd_gap, num_errors, checks_done} = '0;
        for (int i = 0; i < 2; i++)
        begin
            do_init(i[0]);
            do_pd();
            do_rd(16'hA55A);
            do_wr(16'h12EF);
            do_pd();
        end
        // Re-lock after a clock change must hold off the next read
        k = dll_cyc;
        freq_change = 1'b1;
        `WT(dll_cyc != k)
        `CHK(dll_cyc != k, 1'b1)
        freq_change = 1'b0;
        // Power-down asked during a read must wait for the burst to drain
        pd_req = 1'b1;
        do_rd(16'h3CC3);
        `WT(pd_mode !== PD_NONE)
        `CHK(pd_mode, PD_PRECHARGE)
        close_out();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        close_out();
    end
endmodule
`default_nettype wire
